// ### src/opad_decoder.sv
`timescale 1ns/10ps

// Behaviour
// - every relay, holding, data memory and link word is 16 bits, bit 00 to 15.
// - operand without prefix goes to internal or special relay by address alone.
// - data memory is word only; a bit select there is rejected.
// - relay regions allow word or bit access as the instruction asks.
// - bit operand splits into word and bit number 00..15, tens 0/1, units <=5 when tens is 1.
// - word address has 2..4 digits; bit operand has 4..5 digits.
// - timer/counter number gives present value word or completion flag bit.
// - decimal entry stored as BCD, hex entry stored as plain binary.
// - word holds four nibble digits, digit 0 rightmost, digit 3 leftmost.
// - nibble above 9 is invalid as BCD but legal as hexadecimal.
// - only timer values carry a decimal point, rightmost digit being tenths.
// - arithmetic path is integer only, no fractional scaling.
// - unsigned word 0..65535, two words 0..4294967295, never negative.
// - signed word uses bit 15 as sign, range -32768..32767.
// - signed two-word value is two's complement over 32 bits.
// - values 0..32767 have the same pattern signed or unsigned.
module opad_decoder
  import opad_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // request from execution logic
  input  wire logic       op_valid,
  input  wire opad_oper_s op,
  input  wire opad_data_s dat,
  // answer, one cycle after the request
  output logic            res_valid,
  output opad_res_s       res,
  output logic            err_pulse
);

  // ==========================================================
  // address digit checks
  logic [ADDR_DIGITS-1:0] adig_bad;
  logic [3:0]             wdig_bad;

  genvar gi;
  generate
    for (gi = 0; gi < ADDR_DIGITS; gi = gi + 1) begin : g_adig
      opad_nibble_chk u_chk (
        .nib       (op.digits[gi]),
        .over_nine (adig_bad[gi])
      );
    end
    // digit 0 is bits 3:0, digit 3 is bits 15:12
    for (gi = 0; gi < DIGITS_PER_WD; gi = gi + 1) begin : g_wdig
      opad_nibble_chk u_chk (
        .nib       (dat.word_lo[gi*4 +: 4]),
        .over_nine (wdig_bad[gi])
      );
    end
  endgenerate

  // ==========================================================
  // operand split
  wire        is_tmcnt   = (op.prefix == PFX_TIMER_COUNTER);
  wire        is_dmem    = (op.prefix == PFX_DATA_MEM);
  // timer/counter bit access does not split digits
  wire        split_bit  = op.bit_access && !is_tmcnt && !is_dmem;
  wire [3:0]  bit_units  = op.digits[0];
  wire [3:0]  bit_tens   = op.digits[1];
  wire [3:0]  wd0        = split_bit ? op.digits[2] : op.digits[0];
  wire [3:0]  wd1        = split_bit ? op.digits[3] : op.digits[1];
  wire [3:0]  wd2        = split_bit ? op.digits[4] : op.digits[2];
  wire [3:0]  wd3        = split_bit ? 4'h0 : op.digits[3];
  wire [13:0] word_bin   = 14'(wd3 * 1000) + 14'(wd2 * 100) + 14'(wd1 * 10) + 14'(wd0);
  wire [3:0]  bit_bin    = 4'(bit_tens * 10) + bit_units;

  // range check on the two decimal bit digits
  wire        bitnum_bad = split_bit &&
                           ((bit_tens > 4'(BIT_TENS_MAX)) ||
                            ((bit_tens == 4'(BIT_TENS_MAX)) && (bit_units > 4'(BIT_UNITS_MAX))));
  wire        dmem_bit_bad = is_dmem && op.bit_access;
  wire        split_cnt  = op.bit_access && !is_tmcnt;
  wire        count_bad  = split_cnt ?
                           ((op.ndig < 3'(BIT_DIG_MIN)) || (op.ndig > 3'(BIT_DIG_MAX))) :
                           ((op.ndig < 3'(WORD_DIG_MIN)) || (op.ndig > 3'(WORD_DIG_MAX)));
  wire        digit_bad  = |adig_bad;

  // ==========================================================
  // region decode
  // unprefixed addresses run consecutively, so a range compare suffices
  wire        in_special = (word_bin >= 14'(SPEC_WORD_LO)) && (word_bin <= 14'(SPEC_WORD_HI));
  opad_region_e region_sel;
  always_comb begin
    case (op.prefix)
      PFX_NONE:          region_sel = in_special ? special_relay_region : internal_relay_region;
      PFX_HOLDING:       region_sel = holding_relay_region;
      PFX_DATA_MEM:      region_sel = data_memory_region;
      PFX_AUX:           region_sel = aux_relay_region;
      PFX_LINK:          region_sel = link_relay_region;
      default:           region_sel = timer_counter_number;
    endcase
  end

  // ==========================================================
  // word data formats
  // decimal entry packed into four BCD nibbles, hex passes untouched
  wire [13:0] ent        = dat.entry[13:0];
  wire [15:0] bcd_form   = {4'((ent / 1000) % 10), 4'((ent / 100) % 10),
                            4'((ent / 10) % 10), 4'(ent % 10)};
  wire [15:0] store_sel  = dat.entry_dec ? bcd_form : dat.entry;
  // nibbles above nine only count against BCD use
  wire [3:0]  bcd_bad    = dat.as_bcd ? wdig_bad : 4'h0;
  wire [31:0] v_two      = {dat.word_hi, dat.word_lo};
  wire [31:0] v_sext     = {{WORD_BITS{dat.word_lo[SIGN_BIT]}}, dat.word_lo};
  wire [31:0] v_zext     = {16'h0000, dat.word_lo};
  wire [31:0] value_sel  = dat.two_word ? v_two : (dat.is_signed ? v_sext : v_zext);
  // sign bit only matters in signed reading
  wire        neg_sel    = dat.is_signed && value_sel[31];
  // timer words split off the tenths digit; no scaling is applied here
  wire [3:0]  tenths_sel = dat.is_timer ? dat.word_lo[3:0] : 4'h0;
  wire [11:0] whole_sel  = dat.is_timer ? dat.word_lo[15:4] : 12'h000;

  wire        any_err    = bitnum_bad || dmem_bit_bad || count_bad || digit_bad || (|bcd_bad);

  // ==========================================================
  // answer registers
  opad_res_s res_next;
  always_comb begin
    res_next               = res;
    res_next.region        = region_sel;
    res_next.word_addr     = word_bin;
    res_next.bit_num       = split_bit ? bit_bin : 4'h0;
    // bit access kept except in data memory or when the bit number is out of range
    res_next.is_bit        = op.bit_access && !is_dmem && !bitnum_bad;
    res_next.present_value = is_tmcnt && !op.bit_access;
    res_next.count_err     = count_bad;
    res_next.digit_err     = digit_bad;
    res_next.bitnum_err    = bitnum_bad;
    res_next.dmem_bit_err  = dmem_bit_bad;
    res_next.bcd_bad       = bcd_bad;
    res_next.store_word    = store_sel;
    res_next.value32       = value_sel;
    res_next.negative      = neg_sel;
    res_next.timer_tenths  = tenths_sel;
    res_next.timer_whole   = whole_sel;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      err_pulse <= 1'b0;
      res       <= '0;
    end else begin
      res_valid <= op_valid;
      // one pulse per faulty request, not held
      err_pulse <= op_valid && any_err;
      if (op_valid) begin
        res <= res_next;
      end
    end
  end

  // ==========================================================
  // checks
  // helper copies of the request format, so checks on res_valid see what was asked
  logic dat_sig_q;
  logic dat_two_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dat_sig_q <= 1'b0;
      dat_two_q <= 1'b0;
    end else if (op_valid) begin
      dat_sig_q <= dat.is_signed;
      dat_two_q <= dat.two_word;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_req;
    op_valid;
  endsequence

  sequence s_ans;
    res_valid;
  endsequence

  chk_answer_latency: assert property (s_req |=> s_ans)
    else $error("request not answered one cycle later");

  chk_err_cause: assert property (err_pulse |-> $past(op_valid))
    else $error("error pulse without a request");

  chk_dmem_bit_err: assert property (op_valid && op.prefix == PFX_DATA_MEM && op.bit_access
    |=> res.dmem_bit_err && err_pulse && !res.is_bit)
    else $error("data memory bit access not rejected");

  chk_bitnum_range: assert property (res_valid && res.is_bit && res.region != timer_counter_number
    |-> res.bit_num <= 4'(BIT_NUM_MAX) && !res.bitnum_err && !res.dmem_bit_err)
    else $error("bit number above fifteen accepted");

  chk_bad_bit_flag: assert property (op_valid && split_bit && op.digits[1] == 4'h1 && op.digits[0] == 4'h6
    |=> res.bitnum_err && err_pulse)
    else $error("bit 16 not flagged");

  chk_special_select: assert property (op_valid && op.prefix == PFX_NONE && in_special
    |=> res.region == special_relay_region)
    else $error("unprefixed address in special range not resolved");

  chk_tmcnt_map: assert property (op_valid && op.prefix == PFX_TIMER_COUNTER
    |=> res.region == timer_counter_number && res.present_value == !$past(op.bit_access))
    else $error("timer/counter mapping wrong");

  chk_bcd_top_nib: assert property (op_valid && dat.as_bcd && dat.word_lo[15:12] > 4'h9
    |=> res.bcd_bad[3] && err_pulse)
    else $error("leftmost digit above nine not flagged");

  chk_hex_legal: assert property (op_valid && !dat.as_bcd |=> res.bcd_bad == 4'h0)
    else $error("hex nibble wrongly flagged");

  chk_sign_extend: assert property (res_valid && dat_sig_q && !dat_two_q
    |-> res.value32[31:16] == {16{res.value32[15]}} && res.negative == res.value32[15])
    else $error("signed word not sign extended");

  chk_unsigned_pos: assert property (res_valid && !dat_sig_q |-> !res.negative)
    else $error("unsigned value marked negative");

  chk_same_pattern: assert property (res_valid && !dat_two_q && res.value32[15:0] <= 16'(SIGNED16_MAX)
    |-> res.value32[31:16] == 16'h0000)
    else $error("small value differs between signed and unsigned");

  chk_dword_sign: assert property (op_valid && dat.two_word && dat.is_signed
    |=> res.negative == res.value32[31] && res.value32 == $past(v_two))
    else $error("two-word signed value wrong");

  // ==========================================================
  // result field checks
  // count and digit faults pulse the flag too, beyond the three listed causes
  sequence s_fault;
    res.count_err || res.digit_err || res.bitnum_err || res.dmem_bit_err || (|res.bcd_bad);
  endsequence

  chk_fault_pulse: assert property (s_ans ##0 s_fault |-> err_pulse)
    else $error("faulty operand gave no error pulse");

  chk_clean_quiet: assert property (res_valid && !res.count_err && !res.digit_err && !res.bitnum_err
    && !res.dmem_bit_err && res.bcd_bad == 4'h0 |-> !err_pulse)
    else $error("error pulse on a clean operand");

  chk_idle_quiet: assert property (!op_valid |=> !res_valid && !err_pulse)
    else $error("answer without a request");

  chk_res_hold: assert property (!op_valid |=> $stable(res))
    else $error("answer changed without a request");

  chk_ir_select: assert property (op_valid && op.prefix == PFX_NONE && !in_special
    |=> res.region == internal_relay_region)
    else $error("unprefixed address outside special range not internal");

  chk_dmem_word: assert property (op_valid && op.prefix == PFX_DATA_MEM && !op.bit_access
    |=> !res.dmem_bit_err && !res.is_bit)
    else $error("data memory word access rejected");

  chk_relay_bit: assert property (op_valid && op.bit_access && op.digits[1] == 4'h0
    && op.prefix != PFX_DATA_MEM |=> res.is_bit)
    else $error("relay bit access refused");

  chk_word_no_bit: assert property (op_valid && !op.bit_access |=> !res.is_bit && res.bit_num == 4'h0)
    else $error("word access gave a bit");

  chk_tmcnt_no_split: assert property (op_valid && op.prefix == PFX_TIMER_COUNTER
    |=> res.bit_num == 4'h0 && !res.bitnum_err)
    else $error("timer/counter number split into bits");

  chk_hex_store: assert property (op_valid && !dat.entry_dec |=> res.store_word == $past(dat.entry))
    else $error("hex entry not stored as is");

  chk_bcd_low_nib: assert property (op_valid && dat.as_bcd && dat.word_lo[3:0] > 4'h9
    |=> res.bcd_bad[0] && err_pulse)
    else $error("rightmost digit above nine not flagged");

  chk_timer_split: assert property (op_valid && dat.is_timer
    |=> {res.timer_whole, res.timer_tenths} == $past(dat.word_lo))
    else $error("timer tenths digit not split off");

  chk_not_timer: assert property (op_valid && !dat.is_timer
    |=> res.timer_tenths == 4'h0 && res.timer_whole == 12'h000)
    else $error("fraction kept on a non-timer value");

  chk_unsigned_range: assert property (res_valid && !dat_sig_q && !dat_two_q
    |-> res.value32[31:16] == 16'h0000)
    else $error("unsigned word widened with ones");

  chk_dword_unsigned: assert property (op_valid && dat.two_word && !dat.is_signed
    |=> !res.negative && res.value32 == $past(v_two))
    else $error("two-word unsigned value wrong");

  chk_sign_word: assert property (op_valid && dat.is_signed && !dat.two_word
    |=> res.negative == $past(dat.word_lo[SIGN_BIT]))
    else $error("sign not taken from bit 15");

  chk_same_low: assert property (op_valid && !dat.two_word && !dat.word_lo[15]
    |=> res.value32 == {16'h0000, $past(dat.word_lo)})
    else $error("small value pattern differs");

endmodule

// ### pkg/opad_pkg.sv
package opad_pkg;

  // ==========================================================
  // address and digit limits
  localparam int unsigned SPEC_WORD_LO   = 236;
  localparam int unsigned SPEC_WORD_HI   = 299;
  localparam int unsigned BIT_NUM_MAX    = 15;
  localparam int unsigned BIT_TENS_MAX   = 1;
  localparam int unsigned BIT_UNITS_MAX  = 5;
  localparam int unsigned WORD_DIG_MIN   = 2;
  localparam int unsigned WORD_DIG_MAX   = 4;
  localparam int unsigned BIT_DIG_MIN    = 4;
  localparam int unsigned BIT_DIG_MAX    = 5;
  localparam int unsigned BCD_DIGIT_MAX  = 9;
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned SIGN_BIT       = 15;
  localparam int unsigned DIGITS_PER_WD  = 4;
  localparam int unsigned ADDR_DIGITS    = 5;
  localparam int unsigned SIGNED16_MAX   = 32767;

  // ==========================================================
  // reset values
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [31:0] DWORD_RST      = 32'h0000_0000;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PFX_NONE,
    PFX_HOLDING,
    PFX_DATA_MEM,
    PFX_AUX,
    PFX_LINK,
    PFX_TIMER_COUNTER
  } opad_prefix_e;

  typedef enum logic [2:0] {
    internal_relay_region,
    special_relay_region,
    holding_relay_region,
    data_memory_region,
    aux_relay_region,
    link_relay_region,
    timer_counter_number
  } opad_region_e;

  typedef struct packed {
    opad_prefix_e    prefix;
    logic [4:0][3:0] digits;
    logic [2:0]      ndig;
    logic            bit_access;
  } opad_oper_s;

  typedef struct packed {
    logic [15:0] entry;
    logic        entry_dec;
    logic [15:0] word_lo;
    logic [15:0] word_hi;
    logic        as_bcd;
    logic        two_word;
    logic        is_signed;
    logic        is_timer;
  } opad_data_s;

  typedef struct packed {
    opad_region_e region;
    logic [13:0]  word_addr;
    logic [3:0]   bit_num;
    logic         is_bit;
    logic         present_value;
    logic         count_err;
    logic         digit_err;
    logic         bitnum_err;
    logic         dmem_bit_err;
    logic [3:0]   bcd_bad;
    logic [15:0]  store_word;
    logic [31:0]  value32;
    logic         negative;
    logic [3:0]   timer_tenths;
    logic [11:0]  timer_whole;
  } opad_res_s;

endpackage

// ### src/opad_nibble_chk.sv
`timescale 1ns/10ps

// flags a nibble that cannot stand as one decimal digit
module opad_nibble_chk
  import opad_pkg::*;
(
  // nibble in
  input  wire logic [3:0] nib,
  // verdict
  output wire logic       over_nine
);

  assign over_nine = (nib > 4'(BCD_DIGIT_MAX));

endmodule

// ### tb/opad_exec_model.sv
`timescale 1ns/10ps

// ==========================================================
// execution side: one register stage per request
module opad_exec_model
  import opad_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // request from bench
  input  wire logic       req,
  input  wire opad_oper_s req_op,
  input  wire opad_data_s req_dat,
  // toward the decoder
  output logic            op_valid,
  output opad_oper_s      op,
  output opad_data_s      dat
);
  // idle bus shows inverted data so a stale operand never passes as fresh
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_valid <= 1'b0;
      op       <= '0;
      dat      <= '0;
    end else begin
      op_valid <= req;
      op       <= req ? req_op : opad_oper_s'(~op);
      dat      <= req ? req_dat : opad_data_s'(~dat);
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
  import opad_pkg::*;
  logic       clock, rst, req, op_valid, res_valid, err_pulse;
  opad_oper_s req_op, op;
  opad_data_s req_dat, dat;
  opad_res_s  res;
  int         fail_count, n_checks, cyc;
  opad_data_s d0;
  opad_oper_s ow;

  opad_exec_model u_model (.clock(clock), .rst(rst), .req(req), .req_op(req_op), .req_dat(req_dat),
                           .op_valid(op_valid), .op(op), .dat(dat));
  opad_decoder u_dut (.clock(clock), .rst(rst), .op_valid(op_valid), .op(op), .dat(dat),
                      .res_valid(res_valid), .res(res), .err_pulse(err_pulse));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // a hang costs at most this many cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end

  task check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  function automatic opad_oper_s mo(opad_prefix_e p, logic [19:0] g, logic [2:0] n, logic b);
    mo = '{p, g, n, b};
  endfunction

  // flags: as_bcd, two_word, is_signed, is_timer
  function automatic opad_data_s md(logic [15:0] lo, logic [15:0] hi, logic [3:0] fl);
    md = '{16'h0000, 1'b0, lo, hi, fl[3], fl[2], fl[1], fl[0]};
  endfunction

  // answer is settled one cycle after the decoder takes the request
  task send(input opad_oper_s o, input opad_data_s d);
    @(posedge clock);
    req     <= 1'b1;
    req_op  <= o;
    req_dat <= d;
    @(posedge clock);
    req <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task t_unprefixed();
    send(mo(PFX_NONE, 20'h0_0015, 3'h5, 1'b1), d0);
    check(res_valid, 1'b1, "valid");
    check(res.region, internal_relay_region, "region internal");
    check({res.word_addr, res.bit_num, res.is_bit}, {14'h0000, 4'hf, 1'b1}, "bit 15");
    check(err_pulse, 1'b0, "no error");
    @(posedge clock);
    #1;
    check(res_valid, 1'b0, "valid pulse");
    send(mo(PFX_NONE, 20'h2_5200, 3'h5, 1'b1), d0);
    check(res.region, special_relay_region, "region special");
    check({res.word_addr, res.bit_num}, {14'h00fc, 4'h0}, "special word");
    $display("test unprefixed done");
  endtask

  task t_bitnum();
    send(mo(PFX_NONE, 20'h0_0016, 3'h5, 1'b1), d0);
    check({res.bitnum_err, res.is_bit, err_pulse}, 3'b101, "units over 5");
    @(posedge clock);
    #1;
    check(err_pulse, 1'b0, "err pulse");
    send(mo(PFX_HOLDING, 20'h0_1020, 3'h4, 1'b1), d0);
    check({res.bitnum_err, err_pulse}, 2'b11, "tens over 1");
    $display("test bitnum done");
  endtask

  task t_regions();
    send(mo(PFX_DATA_MEM, 20'h0_1250, 3'h4, 1'b1), d0);
    check({res.dmem_bit_err, res.is_bit, err_pulse}, 3'b101, "data memory bit");
    send(mo(PFX_DATA_MEM, 20'h0_1250, 3'h4, 1'b0), d0);
    check({res.region, res.word_addr, err_pulse}, {data_memory_region, 14'h04e2, 1'b0}, "data memory word");
    send(mo(PFX_LINK, 20'h0_1200, 3'h4, 1'b1), d0);
    check({res.region, res.word_addr, res.is_bit}, {link_relay_region, 14'h000c, 1'b1}, "link bit");
    send(mo(PFX_AUX, 20'h0_0012, 3'h2, 1'b0), d0);
    check({res.region, res.word_addr, res.is_bit}, {aux_relay_region, 14'h000c, 1'b0}, "aux word");
    send(mo(PFX_AUX, 20'h0_0012, 3'h1, 1'b0), d0);
    check({res.count_err, res.digit_err, err_pulse}, 3'b101, "one digit word");
    send(mo(PFX_LINK, 20'h0_00a2, 3'h2, 1'b0), d0);
    check({res.count_err, res.digit_err, err_pulse}, 3'b011, "digit above nine");
    send(mo(PFX_TIMER_COUNTER, 20'h0_0215, 3'h3, 1'b0), d0);
    check({res.word_addr, res.present_value, res.is_bit}, {14'h00d7, 2'b10}, "timer present value");
    send(mo(PFX_TIMER_COUNTER, 20'h0_0215, 3'h3, 1'b1), d0);
    check({res.region, res.present_value, res.is_bit}, {timer_counter_number, 2'b01}, "timer flag");
    $display("test regions done");
  endtask

  task t_data();
    send(ow, opad_data_s'{16'h04d2, 1'b1, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0});
    check(res.store_word, 16'h1234, "decimal entry");
    send(ow, opad_data_s'{16'h5f5f, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0});
    check(res.store_word, 16'h5f5f, "hex entry");
    send(ow, md(16'h0b90, 16'h0000, 4'h8));
    check({res.bcd_bad, err_pulse}, 5'b01001, "bcd digit 2");
    send(ow, md(16'ha009, 16'h0000, 4'h8));
    check({res.bcd_bad, err_pulse}, 5'b10001, "bcd digit 3");
    send(ow, md(16'h0b90, 16'h0000, 4'h0));
    check({res.bcd_bad, err_pulse}, 5'b00000, "hex nibble");
    send(ow, md(16'h1235, 16'h0000, 4'h1));
    check({res.timer_whole, res.timer_tenths}, 16'h1235, "timer");
    send(ow, md(16'h1235, 16'h0000, 4'h0));
    check({res.timer_whole, res.timer_tenths}, 16'h0000, "not timer");
    $display("test data done");
  endtask

  task sg(input logic [15:0] lo, input logic [15:0] hi, input logic [3:0] fl, input logic [32:0] e);
    send(ow, md(lo, hi, fl));
    check({res.negative, res.value32}, e, "interpretation");
  endtask

  task t_signs();
    sg(16'h8000, 16'h0000, 4'h2, 33'h1_ffff_8000);
    sg(16'hffff, 16'h0000, 4'h0, 33'h0_0000_ffff);
    sg(16'hffff, 16'hffff, 4'h4, 33'h0_ffff_ffff);
    sg(16'h0000, 16'h8000, 4'h6, 33'h1_8000_0000);
    sg(16'h7fff, 16'h0000, 4'h2, 33'h0_0000_7fff);
    sg(16'h7fff, 16'h0000, 4'h0, 33'h0_0000_7fff);
    sg(16'hffff, 16'h0000, 4'h2, 33'h1_ffff_ffff);
    $display("test signs done");
  endtask

  initial begin
    rst     = 1'b1;
    req     = 1'b0;
    req_op  = '0;
    req_dat = '0;
    d0      = '0;
    ow      = mo(PFX_NONE, 20'h0_0000, 3'h3, 1'b0);
    repeat (20) @(posedge clock);
    check({res_valid, err_pulse}, 2'b00, "reset outputs");
    rst <= 1'b0;
    t_unprefixed();
    t_bitnum();
    t_regions();
    t_data();
    t_signs();
    summarize();
  end
endmodule
